// File: pkg/uepc_pkg.sv
`default_nettype none
package uepc_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // SFR addresses of the endpoint control block.
  localparam logic [7:0] ADDR_FUNCTION_ADDRESS   = 8'h8F;
  localparam logic [7:0] ADDR_DONE_IRQ_ENABLE    = 8'hA2;
  localparam logic [7:0] ADDR_DONE_FLAGS         = 8'hC0;
  localparam logic [7:0] ADDR_ENDPOINT_CONTROL   = 8'hE1;
  localparam logic [7:0] ADDR_ENDPOINT_SELECT    = 8'hF1;
  // Reset values.
  localparam logic [7:0] RST_EP0_CONTROL         = 8'h35;
  localparam logic [7:0] RST_EPN_CONTROL         = 8'h10;
  localparam logic [7:0] RST_ENDPOINT_SELECT     = 8'h80;
  localparam logic [7:0] RST_ZERO                = 8'h00;
  // Endpoint control bit positions.
  localparam int BIT_RX_STALL           = 7;
  localparam int BIT_TX_STALL           = 6;
  localparam int BIT_CONTROL_EP         = 5;
  localparam int BIT_RX_SINGLE_PACKET   = 4;
  localparam int BIT_RX_INPUT_ENABLE    = 3;
  localparam int BIT_RX_ENDPOINT_ENABLE = 2;
  localparam int BIT_TX_OUTPUT_ENABLE   = 1;
  localparam int BIT_TX_ENDPOINT_ENABLE = 0;
  localparam int NUM_EP     = 4;
  localparam int EP_IDX_W   = 2;
  localparam int ADDR_FIELD_W = 7;
  // Token kinds and responses.
  typedef enum logic [1:0] {
    UEPC_TOK_OUT   = 2'h0,
    UEPC_TOK_IN    = 2'h1,
    UEPC_TOK_SETUP = 2'h2
  } uepc_tok_e;
  typedef enum logic [1:0] {
    UEPC_RSP_NONE  = 2'h0,
    UEPC_RSP_ACK   = 2'h1,
    UEPC_RSP_NAK   = 2'h2,
    UEPC_RSP_STALL = 2'h3
  } uepc_rsp_e;
endpackage : uepc_pkg
`default_nettype wire

// File: pkg/uepc_if.sv
`default_nettype none
interface uepc_if (
  input wire logic i_clk,
  input wire logic i_nrst
);
  timeunit 1ns;
  timeprecision 1ps;
  logic                    tok_valid;
  uepc_pkg::uepc_tok_e     tok_kind;
  logic [6:0]              tok_addr;
  logic [1:0]              tok_ep;
  logic                    rsp_valid;
  uepc_pkg::uepc_rsp_e     rsp_code;
  logic                    rsp_write_fifo;
  logic                    rsp_setup;
  modport dev  (input  i_clk, i_nrst, tok_valid, tok_kind, tok_addr, tok_ep,
                output rsp_valid, rsp_code, rsp_write_fifo, rsp_setup);
  modport host (input  i_clk, i_nrst, rsp_valid, rsp_code, rsp_write_fifo, rsp_setup,
                output tok_valid, tok_kind, tok_addr, tok_ep);
endinterface : uepc_if
`default_nettype wire

// File: verilog/uepc_host.sv
`default_nettype none
module uepc_host (
  uepc_if.host               bus,
  input  wire logic          i_req,
  input  wire logic [1:0]    i_kind,
  input  wire logic [6:0]    i_addr,
  input  wire logic [1:0]    i_ep,
  output logic               o_busy,
  output logic               o_done,
  output logic [1:0]         o_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Token issue: one token outstanding, held until the device answers.
  // ----------------------------------------------------------------------
  logic       busy_r, busy_nxt;
  logic       done_r, done_nxt;
  logic [1:0] rsp_r, rsp_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic [1:0] ep_r, ep_nxt;

  always_comb begin
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    rsp_nxt  = rsp_r;
    kind_nxt = kind_r;
    addr_nxt = addr_r;
    ep_nxt   = ep_r;
    if (busy_r && bus.rsp_valid) begin
      busy_nxt = 1'b0;
      done_nxt = 1'b1;
      rsp_nxt  = bus.rsp_code;
    end else if (!busy_r && i_req) begin
      busy_nxt = 1'b1;
      kind_nxt = i_kind;
      addr_nxt = i_addr;
      ep_nxt   = i_ep;
    end
  end

  always_ff @(posedge bus.i_clk or negedge bus.i_nrst) begin
    if (!bus.i_nrst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rsp_r  <= 2'h0;
      kind_r <= 2'h0;
      addr_r <= 7'h00;
      ep_r   <= 2'h0;
    end else begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      rsp_r  <= rsp_nxt;
      kind_r <= kind_nxt;
      addr_r <= addr_nxt;
      ep_r   <= ep_nxt;
    end
  end

  assign bus.tok_valid = busy_r;
  assign bus.tok_kind  = uepc_pkg::uepc_tok_e'(kind_r);
  assign bus.tok_addr  = addr_r;
  assign bus.tok_ep    = ep_r;
  assign o_busy        = busy_r;
  assign o_done        = done_r;
  assign o_rsp         = rsp_r;
endmodule : uepc_host
`default_nettype wire

// File: verilog/uepc_device.sv
`default_nettype none
// What this block does
// - Two-bit index selects endpoint registers
// - Software writes zeros to index bits 6:2
// - Rx stall answers OUT with STALL unless a SETUP is pending
// - Tx stall answers IN with STALL
// - Only control endpoints accept SETUP tokens
// - Single-packet mode allows one buffered packet
// - Control endpoints preferably use single-packet mode
// - Rx input disabled: discard data, NAK
// - Rx endpoint disabled: no OUT/SETUP response
// - Tx output disabled: NAK IN tokens
// - Tx endpoint disabled: no IN response
// - Control resets: ep0 35h, others 10h
// - Seven-bit function address, bit 7 reserved
// - Firmware writes address once at configuration
// - Interrupt enables: odd rx, even tx
// - Enabled done flag raises processor interrupt
// - Done flags hardware-set, software clear/set
module uepc_device (
  uepc_if.dev                bus,
  input  wire logic          i_sfr_wr,
  input  wire logic          i_sfr_rd,
  input  wire logic [7:0]    i_sfr_addr,
  input  wire logic [7:0]    i_sfr_wdata,
  output logic [7:0]         o_sfr_rdata,
  output logic               o_sfr_hit,
  input  wire logic          i_rx_release,
  input  wire logic [3:0]    i_rx_done_evt,
  input  wire logic [3:0]    i_tx_done_evt,
  output logic               o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = uepc_pkg::NUM_EP;

  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  logic [7:0]   ctl_r   [N];
  logic [7:0]   ctl_nxt [N];
  logic [1:0]   idx_r, idx_nxt;
  logic         idx7_r, idx7_nxt;
  logic [6:0]   function_address_r, function_address_nxt;
  logic [7:0]   fie_r, fie_nxt;
  logic [7:0]   flg_r, flg_nxt;
  logic [N-1:0] rx_pkts_r, rx_pkts_nxt;
  logic [N-1:0] setup_pend_r, setup_pend_nxt;
  logic         rsp_valid_r, rsp_valid_nxt;
  logic [1:0]   rsp_code_r, rsp_code_nxt;
  logic         rsp_wr_r, rsp_wr_nxt;
  logic         rsp_setup_r, rsp_setup_nxt;

  logic wr_ctl, wr_idx, wr_function_address, wr_fie, wr_flg;
  assign wr_ctl   = i_sfr_wr && (i_sfr_addr == uepc_pkg::ADDR_ENDPOINT_CONTROL);
  assign wr_idx   = i_sfr_wr && (i_sfr_addr == uepc_pkg::ADDR_ENDPOINT_SELECT);
  assign wr_function_address = i_sfr_wr && (i_sfr_addr == uepc_pkg::ADDR_FUNCTION_ADDRESS);
  assign wr_fie   = i_sfr_wr && (i_sfr_addr == uepc_pkg::ADDR_DONE_IRQ_ENABLE);
  assign wr_flg   = i_sfr_wr && (i_sfr_addr == uepc_pkg::ADDR_DONE_FLAGS);

  // ----------------------------------------------------------------------
  // Token decision, combinational from the sampled control bits.
  // ----------------------------------------------------------------------
  logic [7:0] tc;
  logic       tok_take, rx_full;
  logic [1:0] dec_code;
  logic       dec_answer, dec_wr, dec_setup;

  assign tc       = ctl_r[bus.tok_ep];
  assign tok_take = bus.tok_valid && !rsp_valid_r && (bus.tok_addr == function_address_r);

  always_comb begin
    dec_answer = 1'b1;
    dec_code   = uepc_pkg::UEPC_RSP_ACK;
    dec_wr     = 1'b0;
    dec_setup  = 1'b0;
    // Dual mode never reports full; rx_pkts is a one-bit flag per endpoint, used only in single-packet mode.
    rx_full    = rx_pkts_r[bus.tok_ep] && tc[uepc_pkg::BIT_RX_SINGLE_PACKET];
    case (bus.tok_kind)
      uepc_pkg::UEPC_TOK_IN: begin
        if (!tc[uepc_pkg::BIT_TX_ENDPOINT_ENABLE]) begin
          dec_answer = 1'b0;
        end else if (tc[uepc_pkg::BIT_TX_STALL]) begin
          dec_code = uepc_pkg::UEPC_RSP_STALL;
        end else if (!tc[uepc_pkg::BIT_TX_OUTPUT_ENABLE]) begin
          dec_code = uepc_pkg::UEPC_RSP_NAK;
        end
      end
      uepc_pkg::UEPC_TOK_SETUP: begin
        if (!tc[uepc_pkg::BIT_RX_ENDPOINT_ENABLE] || !tc[uepc_pkg::BIT_CONTROL_EP]) begin
          dec_answer = 1'b0;
        end else begin
          // Stall and input enable do not block SETUP.
          dec_wr    = 1'b1;
          dec_setup = 1'b1;
        end
      end
      uepc_pkg::UEPC_TOK_OUT: begin
        if (!tc[uepc_pkg::BIT_RX_ENDPOINT_ENABLE]) begin
          dec_answer = 1'b0;
          // A pending SETUP lifts the stall so the control transfer can finish.
        end else if (tc[uepc_pkg::BIT_RX_STALL] && !setup_pend_r[bus.tok_ep]) begin
          dec_code = uepc_pkg::UEPC_RSP_STALL;
        end else if (!tc[uepc_pkg::BIT_RX_INPUT_ENABLE] || rx_full) begin
          dec_code = uepc_pkg::UEPC_RSP_NAK;
        end else begin
          dec_wr = 1'b1;
        end
      end
      default: begin
        dec_answer = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next-state logic for registers and answer.
  // ----------------------------------------------------------------------
  always_comb begin
    idx_nxt   = idx_r;
    idx7_nxt  = idx7_r;
    function_address_nxt = function_address_r;
    fie_nxt   = fie_r;
    rx_pkts_nxt   = rx_pkts_r;
    setup_pend_nxt = setup_pend_r;
    rsp_valid_nxt = 1'b0;
    rsp_code_nxt  = rsp_code_r;
    rsp_wr_nxt    = 1'b0;
    rsp_setup_nxt = 1'b0;
    for (int e = 0; e < N; e++) begin
      ctl_nxt[e] = ctl_r[e];
    end
    if (wr_idx) begin
      idx_nxt  = i_sfr_wdata[uepc_pkg::EP_IDX_W-1:0];
      idx7_nxt = i_sfr_wdata[7];
    end
    if (wr_ctl) begin
      ctl_nxt[idx_r] = i_sfr_wdata;
    end
    if (wr_function_address) begin
      function_address_nxt = i_sfr_wdata[uepc_pkg::ADDR_FIELD_W-1:0];
    end
    if (wr_fie) begin
      fie_nxt = i_sfr_wdata;
    end
    if (i_rx_release) begin
      // Releasing the packet also retires the SETUP that it carried.
      rx_pkts_nxt[idx_r] = 1'b0;
      setup_pend_nxt[idx_r] = 1'b0;
    end
    if (tok_take && dec_answer) begin
      rsp_valid_nxt = 1'b1;
      rsp_code_nxt  = dec_code;
      rsp_wr_nxt    = dec_wr;
      rsp_setup_nxt = dec_setup;
      if (dec_wr) begin
        rx_pkts_nxt[bus.tok_ep] = 1'b1;
      end
      if (dec_setup) begin
        setup_pend_nxt[bus.tok_ep] = 1'b1;
      end
    end
  end

  // Done flags: hardware set wins over a software write in the same cycle.
  genvar g;
  for (g = 0; g < N; g++) begin : g_flag
    always_comb begin
      flg_nxt[2*g+1] = (wr_flg ? i_sfr_wdata[2*g+1] : flg_r[2*g+1])
                       || i_rx_done_evt[g];
      flg_nxt[2*g]   = (wr_flg ? i_sfr_wdata[2*g] : flg_r[2*g])
                       || i_tx_done_evt[g];
    end
  end

  always_ff @(posedge bus.i_clk or negedge bus.i_nrst) begin
    if (!bus.i_nrst) begin
      ctl_r[0] <= uepc_pkg::RST_EP0_CONTROL;
      for (int e = 1; e < N; e++) begin
        ctl_r[e] <= uepc_pkg::RST_EPN_CONTROL;
      end
      idx_r       <= uepc_pkg::RST_ENDPOINT_SELECT[1:0];
      idx7_r      <= uepc_pkg::RST_ENDPOINT_SELECT[7];
      function_address_r     <= uepc_pkg::RST_ZERO[6:0];
      fie_r       <= uepc_pkg::RST_ZERO;
      flg_r       <= uepc_pkg::RST_ZERO;
      rx_pkts_r   <= '0;
      setup_pend_r <= '0;
      rsp_valid_r <= 1'b0;
      rsp_code_r  <= 2'h0;
      rsp_wr_r    <= 1'b0;
      rsp_setup_r <= 1'b0;
    end else begin
      for (int e = 0; e < N; e++) begin
        ctl_r[e] <= ctl_nxt[e];
      end
      idx_r       <= idx_nxt;
      idx7_r      <= idx7_nxt;
      function_address_r     <= function_address_nxt;
      fie_r       <= fie_nxt;
      flg_r       <= flg_nxt;
      rx_pkts_r   <= rx_pkts_nxt;
      setup_pend_r <= setup_pend_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_code_r  <= rsp_code_nxt;
      rsp_wr_r    <= rsp_wr_nxt;
      rsp_setup_r <= rsp_setup_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Read path and outputs.
  // ----------------------------------------------------------------------
  always_comb begin
    o_sfr_rdata = 8'h00;
    o_sfr_hit   = 1'b1;
    case (i_sfr_addr)
      uepc_pkg::ADDR_ENDPOINT_CONTROL: o_sfr_rdata = ctl_r[idx_r];
      uepc_pkg::ADDR_ENDPOINT_SELECT:  o_sfr_rdata = {idx7_r, 5'h00, idx_r};
      uepc_pkg::ADDR_FUNCTION_ADDRESS: o_sfr_rdata = {1'b0, function_address_r};
      uepc_pkg::ADDR_DONE_IRQ_ENABLE:  o_sfr_rdata = fie_r;
      uepc_pkg::ADDR_DONE_FLAGS:       o_sfr_rdata = flg_r;
      default:                         o_sfr_hit   = 1'b0;
    endcase
    if (!i_sfr_rd) begin
      o_sfr_rdata = 8'h00;
    end
  end

  assign o_irq              = |(flg_r & fie_r);
  assign bus.rsp_valid      = rsp_valid_r;
  assign bus.rsp_code       = uepc_pkg::uepc_rsp_e'(rsp_code_r);
  assign bus.rsp_write_fifo = rsp_wr_r;
  assign bus.rsp_setup      = rsp_setup_r;
endmodule : uepc_device
`default_nettype wire

// File: testbench/uepc_checker.sv
`default_nettype none
module uepc_checker (
  input wire logic                i_clk,
  input wire logic                i_nrst,
  input wire logic                tok_valid,
  input wire uepc_pkg::uepc_tok_e tok_kind,
  input wire logic                rsp_valid,
  input wire uepc_pkg::uepc_rsp_e rsp_code,
  input wire logic                rsp_write_fifo,
  input wire logic                rsp_setup
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Answer checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(tok_valid))
    else $error("answer without a token");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  AST_RSP_CODE: assert property (rsp_valid |-> rsp_code != uepc_pkg::UEPC_RSP_NONE)
    else $error("answer carries no code");
  AST_FIFO_ACK: assert property (rsp_write_fifo |-> rsp_valid && rsp_code == uepc_pkg::UEPC_RSP_ACK)
    else $error("fifo write without ack");
  AST_SETUP_FIFO: assert property (rsp_setup |-> rsp_write_fifo)
    else $error("setup not stored");
  AST_SETUP_ACK: assert property (rsp_valid && $past(tok_kind) == uepc_pkg::UEPC_TOK_SETUP
    |-> rsp_code == uepc_pkg::UEPC_RSP_ACK && rsp_setup)
    else $error("setup answered other than ack");
  AST_IN_NO_WRITE: assert property (rsp_valid && $past(tok_kind) == uepc_pkg::UEPC_TOK_IN
    |-> !rsp_write_fifo && !rsp_setup)
    else $error("in token wrote fifo");
  AST_OUT_NO_SETUP: assert property (rsp_valid && $past(tok_kind) == uepc_pkg::UEPC_TOK_OUT
    |-> !rsp_setup)
    else $error("out token flagged setup");
endmodule : uepc_checker
`default_nettype wire

// File: testbench/uepc_tb_top.sv
`default_nettype none
module uepc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] S_IDX = uepc_pkg::ADDR_ENDPOINT_SELECT;
  localparam logic [7:0] S_CTL = uepc_pkg::ADDR_ENDPOINT_CONTROL;
  localparam logic [7:0] S_FA = uepc_pkg::ADDR_FUNCTION_ADDRESS;
  localparam logic [7:0] S_IE = uepc_pkg::ADDR_DONE_IRQ_ENABLE;
  localparam logic [7:0] S_FL = uepc_pkg::ADDR_DONE_FLAGS;
  localparam logic [1:0] T_OUT = 2'h0, T_IN = 2'h1, T_SU = 2'h2;
  localparam logic [1:0] R_NO = 2'h0, R_ACK = 2'h1, R_NAK = 2'h2, R_STL = 2'h3;
  logic       i_clk, i_nrst, req, sfr_wr, sfr_rd, rx_rel, irq, hit, busy, done;
  logic [1:0] kind, ep, rsp;
  logic [6:0] taddr;
  logic [7:0] saddr, wdata, rdata;
  logic [3:0] rx_evt, tx_evt;
  int         err_total, n_tests;
  uepc_if u_uepc_if (.i_clk(i_clk), .i_nrst(i_nrst));
  uepc_host u_uepc_host (.bus(u_uepc_if), .i_req(req), .i_kind(kind), .i_addr(taddr),
    .i_ep(ep), .o_busy(busy), .o_done(done), .o_rsp(rsp));
  uepc_device u_uepc_device (.bus(u_uepc_if), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd),
    .i_sfr_addr(saddr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .i_rx_release(rx_rel), .i_rx_done_evt(rx_evt), .i_tx_done_evt(tx_evt), .o_irq(irq));
  uepc_checker u_uepc_checker (.i_clk(i_clk), .i_nrst(i_nrst),
    .tok_valid(u_uepc_if.tok_valid), .tok_kind(u_uepc_if.tok_kind),
    .rsp_valid(u_uepc_if.rsp_valid), .rsp_code(u_uepc_if.rsp_code),
    .rsp_write_fifo(u_uepc_if.rsp_write_fifo), .rsp_setup(u_uepc_if.rsp_setup));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic reset_dut();
    i_nrst <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
  endtask : reset_dut
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    sfr_wr <= 1'b1;
    saddr <= a;
    wdata <= d;
    @(posedge i_clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    sfr_rd <= 1'b1;
    saddr <= a;
    @(negedge i_clk);
    chk(rdata, exp, "read");
    chk({7'h0, hit}, {7'h0, (a inside {S_IDX, S_CTL, S_FA, S_IE, S_FL})}, "hit");
    @(posedge i_clk);
    sfr_rd <= 1'b0;
  endtask : rd
  // A silent endpoint leaves the host waiting forever, so both ends are reset afterwards.
  task automatic tok(input logic [1:0] k, input logic [1:0] e, input logic [6:0] a,
                     input logic [1:0] exp);
    logic got;
    got = 1'b0;
    @(posedge i_clk);
    req <= 1'b1;
    kind <= k;
    ep <= e;
    taddr <= a;
    @(posedge i_clk);
    req <= 1'b0;
    repeat (8) begin
      @(negedge i_clk);
      if (done === 1'b1) got = 1'b1;
    end
    chk({7'h0, got}, {7'h0, exp != R_NO}, "answered");
    chk({7'h0, busy}, {7'h0, exp == R_NO}, "busy");
    if (exp == R_NO) reset_dut();
    else chk({6'h0, rsp}, {6'h0, exp}, "response");
  endtask : tok
  task automatic evt(input logic [3:0] rx, input logic [3:0] tx, input logic exp_irq);
    @(posedge i_clk);
    rx_evt <= rx;
    tx_evt <= tx;
    @(posedge i_clk);
    rx_evt <= 4'h0;
    tx_evt <= 4'h0;
    @(negedge i_clk);
    chk({7'h0, irq}, {7'h0, exp_irq}, "irq");
  endtask : evt
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(S_IDX, 8'h80);
    for (int i = 3; i >= 0; i--) begin
      wr(S_IDX, 8'(i));
      rd(S_CTL, (i == 0) ? 8'h35 : 8'h10);
    end
    rd(S_FA, 8'h00);
    rd(S_IE, 8'h00);
    rd(8'h55, 8'h00);
    wr(S_IDX, 8'h02);
    wr(S_CTL, 8'h3F);
    wr(S_IDX, 8'h01);
    rd(S_CTL, 8'h10);
    wr(S_IDX, 8'h02);
    rd(S_CTL, 8'h3F);
    wr(S_IDX, 8'h00);
  endtask : t_regs
  task automatic t_in();
    tok(T_IN, 2'h0, 7'h0, R_NAK);
    wr(S_CTL, 8'h37);
    tok(T_IN, 2'h0, 7'h0, R_ACK);
    wr(S_CTL, 8'h75);
    tok(T_IN, 2'h0, 7'h0, R_STL);
    wr(S_CTL, 8'h76);
    tok(T_IN, 2'h0, 7'h0, R_NO);
  endtask : t_in
  task automatic t_out();
    tok(T_OUT, 2'h0, 7'h0, R_NAK);
    wr(S_CTL, 8'h3D);
    tok(T_OUT, 2'h0, 7'h0, R_ACK);
    tok(T_OUT, 2'h0, 7'h0, R_NAK);
    @(posedge i_clk);
    rx_rel <= 1'b1;
    @(posedge i_clk);
    rx_rel <= 1'b0;
    tok(T_OUT, 2'h0, 7'h0, R_ACK);
    wr(S_CTL, 8'h2D);
    tok(T_OUT, 2'h0, 7'h0, R_ACK);
    wr(S_CTL, 8'hB5);
    tok(T_OUT, 2'h0, 7'h0, R_STL);
    tok(T_SU, 2'h0, 7'h0, R_ACK);
    tok(T_OUT, 2'h0, 7'h0, R_NAK);
    @(posedge i_clk);
    rx_rel <= 1'b1;
    @(posedge i_clk);
    rx_rel <= 1'b0;
    tok(T_OUT, 2'h0, 7'h0, R_STL);
    wr(S_CTL, 8'hB9);
    tok(T_OUT, 2'h0, 7'h0, R_NO);
    wr(S_CTL, 8'h31);
    tok(T_SU, 2'h0, 7'h0, R_NO);
    wr(S_IDX, 8'h01);
    wr(S_CTL, 8'h1C);
    tok(T_OUT, 2'h1, 7'h0, R_ACK);
    tok(T_SU, 2'h1, 7'h0, R_NO);
  endtask : t_out
  task automatic t_addr();
    wr(S_FA, 8'h05);
    rd(S_FA, 8'h05);
    wr(S_CTL, 8'h37);
    tok(T_IN, 2'h0, 7'h05, R_ACK);
    tok(T_IN, 2'h0, 7'h00, R_NO);
  endtask : t_addr
  task automatic t_irq();
    wr(S_IE, 8'h02);
    evt(4'h0, 4'h1, 1'b0);
    rd(S_FL, 8'h01);
    evt(4'h1, 4'h0, 1'b1);
    wr(S_FL, 8'h00);
    evt(4'h0, 4'h0, 1'b0);
    wr(S_IE, 8'h80);
    wr(S_FL, 8'h40);
    evt(4'h8, 4'h0, 1'b1);
    rd(S_FL, 8'hC0);
  endtask : t_irq
  task automatic final_report();
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #200us;
    err_total++;
    final_report();
  end
  initial begin
    err_total = 0;
    n_tests = 0;
    i_nrst = 1'b0;
    {req, sfr_wr, sfr_rd, rx_rel, kind, ep, taddr, saddr, wdata, rx_evt, tx_evt} = '0;
    reset_dut();
    t_regs();
    t_in();
    t_out();
    t_addr();
    t_irq();
    final_report();
  end
endmodule : uepc_tb_top
`default_nettype wire
